// *** core/ree_pkg.sv ***
// package of constants, types and operators for the register event engine
package ree_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_SLOTS = 20;
	localparam int DATA_W    = 16;
	localparam int SLOT_W    = 5;
	localparam int CNT_W     = 16;
	localparam int IDX_W     = 10;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CFG    = 10'h2a8;
	localparam logic [IDX_W-1:0] IDX_TRGSEL = 10'h2bc;
	localparam logic [IDX_W-1:0] IDX_TRGOPD = 10'h2d0;
	localparam logic [IDX_W-1:0] IDX_SRCSEL = 10'h2e4;
	localparam logic [IDX_W-1:0] IDX_SRCOPD = 10'h2f8;
	localparam logic [IDX_W-1:0] IDX_DSTSEL = 10'h30c;
	localparam logic [IDX_W-1:0] IDX_CTRL   = 10'h320;
	localparam logic [IDX_W-1:0] IDX_STAT   = 10'h321;
	localparam logic [IDX_W-1:0] IDX_EXEC   = 10'h322;
	localparam logic [IDX_W-1:0] IDX_STRIDE = 10'h014;

	// ----------------------------------------------------------------
	// event_action_config fields
	// ----------------------------------------------------------------
	localparam int TRIG_OP_LSB = 0;
	localparam int FILT_LSB    = 4;
	localparam int TTYPE_LSB   = 8;
	localparam int EXEC_OP_LSB = 12;
	localparam int FIELD_W     = 4;

	// control and status bits
	localparam int CTRL_RUN_BIT   = 0;
	localparam int STAT_BUSY_BIT  = 1;
	localparam int STAT_OVRUN_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] SLOT_RST = 16'h0000;
	localparam logic              RUN_RST  = 1'b1;
	localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int REG_PERIOD_NS   = 500_000;
	localparam int REG_TICK_CYCLES = (REG_PERIOD_NS * 1000) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// operator and trigger type codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_TRUE = 4'h0, OP_EQ = 4'h1, OP_NE = 4'h2, OP_LT = 4'h3,
		OP_GT = 4'h4, OP_OR = 4'h5, OP_NOR = 4'h6, OP_AND = 4'h7,
		OP_NAND = 4'h8, OP_XOR = 4'h9, OP_XNOR = 4'ha, OP_ADD = 4'hb,
		OP_SUB = 4'hc, OP_MUL = 4'hd, OP_DIV = 4'he, OP_VALUE = 4'hf
	} ree_op_t;

	localparam logic [3:0] TT_ACTIVE = 4'h0;
	localparam logic [3:0] TT_EDGE   = 4'h1;
	localparam logic [3:0] TT_REPEAT = 4'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_TRIG  = 4'b0010,
		ST_SRC   = 4'b0100,
		ST_WRITE = 4'b1000
	} ree_state_t;

endpackage : ree_pkg

// *** core/ree_engine.sv ***
// register event engine: twenty slots turning register conditions into register writes
//
// How it works
// (R01) Twenty independent slots, each with its own trigger and execution settings.
// (R02) A regulator tick every 500 us starts one pass over all slots.
// (R03) Raw trigger is active when register OPERATOR operand is nonzero.
// (R04) Trigger examines the register numbered by trigger_reg_select.
// (R05) Trigger operator is bits 3..0 of event_action_config, sixteen codes.
// (R06) Trigger operand comes from trigger_operand.
// (R07) Codes 0..10: true, eq, ne, lt, gt, or, nor, and, nand, xor, xnor.
// (R08) Codes 11..15: add, subtract, multiply, divide, pass operand.
// (R09) Filter needs the raw trigger active on consecutive evaluations.
// (R10) Filter bits 7..4: zero means none, n means 2^n evaluations.
// (R11) Trigger type bits 11..8 choose active, edge or repeat.
// (R12) Type 0 executes on every pass the filtered trigger is true.
// (R13) Type 1 executes once per rising filtered trigger, rearms when inactive.
// (R14) Type 2 executes repeatedly, clearing filter count after each execution.
// (R15) Execution combines source register and operand with the same operators.
// (R16) Source register is numbered by source_reg_select.
// (R17) Execution operator is bits 15..12 of event_action_config.
// (R18) Execution operand comes from source_operand.
// (R19) Result is written to the register numbered by dest_reg_select.
// (R20) A zero configuration disables the slot with no side effects.
// (R21) Nonzero config with trigger operator 0 fires each pass. Here operator 0 only forces the raw trigger; filter and type still gate it.
// (R22) Software must not use events to defeat shutdown or quick-stop.
// (R23) Both operands of each slot are 16-bit values.
// (R24) Comparisons give 1 or 0; arithmetic truncates; divide by zero gives zero.
// (R25) Slots run in ascending order; earlier writes are seen by later slots.
//
// Added by the designer: the register offsets and the Wishbone register port.
module ree_engine
	import ree_pkg::*;
#(
	parameter int TICK_CYCLES = ree_pkg::REG_TICK_CYCLES
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	// wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [11:0]                 wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	// device register space
	output logic      [ree_pkg::DATA_W-1:0]  rd_addr_o,
	input  wire logic [ree_pkg::DATA_W-1:0]  rd_data_i,
	output logic                             wr_en_o,
	output logic      [ree_pkg::DATA_W-1:0]  wr_addr_o,
	output logic      [ree_pkg::DATA_W-1:0]  wr_data_o
);
	import ree_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] ree_alu(
		input logic [3:0]        op,
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		logic [31:0]       prod;
		logic [DATA_W-1:0] res;
		prod = a * b;
		res  = '0;
		// (R07) logic and compare codes
		// (R08) arithmetic and pass codes
		// (R24) flag results, truncation, safe divide
		case (ree_op_t'(op))
			OP_TRUE:  res = 16'h0001;
			OP_EQ:    res = {15'h0000, a == b};
			OP_NE:    res = {15'h0000, a != b};
			OP_LT:    res = {15'h0000, a < b};
			OP_GT:    res = {15'h0000, a > b};
			OP_OR:    res = a | b;
			OP_NOR:   res = ~(a | b);
			OP_AND:   res = a & b;
			OP_NAND:  res = ~(a & b);
			OP_XOR:   res = a ^ b;
			OP_XNOR:  res = ~(a ^ b);
			OP_ADD:   res = DATA_W'(a + b);
			OP_SUB:   res = DATA_W'(a - b);
			OP_MUL:   res = prod[DATA_W-1:0];
			OP_DIV:   res = (b == '0) ? '0 : a / b;
			OP_VALUE: res = b;
			default:  res = '0;
		endcase
		return res;
	endfunction : ree_alu

	// byte lanes 0 and 1 carry the 16-bit settings
	function automatic logic [DATA_W-1:0] ree_merge(
		input logic [DATA_W-1:0] old,
		input logic [31:0]       dat,
		input logic [3:0]        sel
	);
		logic [DATA_W-1:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = dat[15:8];
		end
		return res;
	endfunction : ree_merge

	// ----------------------------------------------------------------
	// slot settings
	// ----------------------------------------------------------------
	// (R01) per-slot settings and state
	logic [DATA_W-1:0] cfg_q     [NUM_SLOTS];
	logic [DATA_W-1:0] trg_sel_q [NUM_SLOTS];
	logic [DATA_W-1:0] trg_opd_q [NUM_SLOTS];
	logic [DATA_W-1:0] src_sel_q [NUM_SLOTS];
	logic [DATA_W-1:0] src_opd_q [NUM_SLOTS];
	logic [DATA_W-1:0] dst_sel_q [NUM_SLOTS];
	logic [CNT_W-1:0]  filt_cnt  [NUM_SLOTS];
	logic              filt_prev [NUM_SLOTS];

	ree_state_t        state;
	ree_state_t        next_state;
	logic              run;
	logic              overrun;
	logic [NUM_SLOTS-1:0] exec_mask;
	logic [NUM_SLOTS-1:0] exec_acc;

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	logic [IDX_W-1:0]  idx;
	logic              bus_req;
	logic              bus_wr;
	logic [2:0]        grp;
	logic              grp_hit;
	logic [SLOT_W-1:0] grp_slot;
	logic [IDX_W-1:0]  rel;

	assign idx     = wb_adr_i[11:2];
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr  = bus_req & wb_we_i;

	always_comb begin
		grp      = 3'd0;
		grp_hit  = 1'b0;
		grp_slot = '0;
		rel      = '0;
		for (int g = 0; g < 6; g++) begin
			if (idx >= IDX_CFG + IDX_W'(g) * IDX_STRIDE &&
				idx < IDX_CFG + IDX_W'(g + 1) * IDX_STRIDE) begin
				grp      = 3'(g);
				grp_hit  = 1'b1;
				rel      = idx - IDX_CFG - IDX_W'(g) * IDX_STRIDE;
				grp_slot = rel[SLOT_W-1:0];
			end
		end
	end

	// single-cycle answer; ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// unmapped indices answer with zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= 32'h0000_0000;
			if (grp_hit) begin
				unique case (grp)
					3'd0:    wb_dat_o[DATA_W-1:0] <= cfg_q[grp_slot];
					3'd1:    wb_dat_o[DATA_W-1:0] <= trg_sel_q[grp_slot];
					3'd2:    wb_dat_o[DATA_W-1:0] <= trg_opd_q[grp_slot];
					3'd3:    wb_dat_o[DATA_W-1:0] <= src_sel_q[grp_slot];
					3'd4:    wb_dat_o[DATA_W-1:0] <= src_opd_q[grp_slot];
					default: wb_dat_o[DATA_W-1:0] <= dst_sel_q[grp_slot];
				endcase
			end else if (idx == IDX_CTRL) begin
				wb_dat_o[CTRL_RUN_BIT] <= run;
			end else if (idx == IDX_STAT) begin
				wb_dat_o[STAT_BUSY_BIT]  <= ~state[0];
				wb_dat_o[STAT_OVRUN_BIT] <= overrun;
			end else if (idx == IDX_EXEC) begin
				wb_dat_o[NUM_SLOTS-1:0] <= exec_mask;
			end
		end
	end

	// (R23) sixteen-bit settings written through lanes 0 and 1
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				cfg_q[s]     <= SLOT_RST;
				trg_sel_q[s] <= SLOT_RST;
				trg_opd_q[s] <= SLOT_RST;
				src_sel_q[s] <= SLOT_RST;
				src_opd_q[s] <= SLOT_RST;
				dst_sel_q[s] <= SLOT_RST;
			end
		end else if (bus_wr && grp_hit) begin
			unique case (grp)
				3'd0:    cfg_q[grp_slot]     <= ree_merge(cfg_q[grp_slot], wb_dat_i, wb_sel_i);
				3'd1:    trg_sel_q[grp_slot] <= ree_merge(trg_sel_q[grp_slot], wb_dat_i, wb_sel_i);
				3'd2:    trg_opd_q[grp_slot] <= ree_merge(trg_opd_q[grp_slot], wb_dat_i, wb_sel_i);
				3'd3:    src_sel_q[grp_slot] <= ree_merge(src_sel_q[grp_slot], wb_dat_i, wb_sel_i);
				3'd4:    src_opd_q[grp_slot] <= ree_merge(src_opd_q[grp_slot], wb_dat_i, wb_sel_i);
				default: dst_sel_q[grp_slot] <= ree_merge(dst_sel_q[grp_slot], wb_dat_i, wb_sel_i);
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run <= RUN_RST;
		end else if (bus_wr && idx == IDX_CTRL && wb_sel_i[0]) begin
			run <= wb_dat_i[CTRL_RUN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// regulator tick
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt;
	logic        tick;

	// (R02) one pass every regulator period
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tick_cnt <= 32'h0000_0000;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1)) & run;

	// ----------------------------------------------------------------
	// slot sequencer
	// ----------------------------------------------------------------
	logic [SLOT_W-1:0] slot;
	logic              last_slot;
	logic [DATA_W-1:0] cur_cfg;
	logic [3:0]        filt_set;
	logic [3:0]        ttype;
	logic [CNT_W-1:0]  target;
	logic              raw;
	logic [CNT_W-1:0]  next_cnt;
	logic              filtered;
	logic              fire;

	assign last_slot = (slot == SLOT_W'(NUM_SLOTS - 1));
	assign cur_cfg   = cfg_q[slot];
	assign filt_set  = cur_cfg[FILT_LSB +: FIELD_W];
	assign ttype     = cur_cfg[TTYPE_LSB +: FIELD_W];

	// (R04) trigger register, then (R16) source register, on the read port
	always_comb begin
		rd_addr_o = trg_sel_q[slot];
		if (state == ST_SRC) begin
			rd_addr_o = src_sel_q[slot];
		end
	end

	always_comb begin
		// (R10) 2^n evaluations, one when unfiltered
		target = CNT_W'(17'h0_0001 << filt_set);
		// (R03) (R05) (R06) nonzero result arms the trigger
		raw = (ree_alu(cur_cfg[TRIG_OP_LSB +: FIELD_W], rd_data_i, trg_opd_q[slot]) != '0);
		// (R09) consecutive count, saturating at the target
		if (!raw) begin
			next_cnt = '0;
		end else if (filt_cnt[slot] >= target) begin
			next_cnt = target;
		end else begin
			next_cnt = filt_cnt[slot] + CNT_W'(1);
		end
		filtered = raw && (next_cnt == target);
		// (R11) trigger behaviour; unlisted types never execute
		// (R21) operator 0 is always raw-active
		unique case (ttype)
			// (R12) every true pass
			TT_ACTIVE: fire = filtered;
			// (R13) rising filtered condition only
			TT_EDGE:   fire = filtered && !filt_prev[slot];
			// (R14) repeat at filter spacing
			TT_REPEAT: fire = filtered;
			default:   fire = 1'b0;
		endcase
		// (R20) disabled slot
		if (cur_cfg == '0) begin
			fire = 1'b0;
		end
	end

	// (R25) slots in ascending order, one write finished before the next read
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:  if (tick) next_state = ST_TRIG;
			ST_TRIG:  if (fire) next_state = ST_SRC;
				else if (last_slot) next_state = ST_IDLE;
			ST_SRC:   next_state = ST_WRITE;
			ST_WRITE: next_state = last_slot ? ST_IDLE : ST_TRIG;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			slot <= '0;
		end else if (state == ST_IDLE) begin
			slot <= '0;
		end else if ((state == ST_TRIG && !fire) || state == ST_WRITE) begin
			slot <= last_slot ? '0 : slot + SLOT_W'(1);
		end
	end

	// filter state only moves for enabled slots
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				filt_cnt[s]  <= CNT_RST;
				filt_prev[s] <= 1'b0;
			end
		end else if (state == ST_TRIG && cur_cfg != '0) begin
			// (R14) count restarts after a repeat execution
			filt_cnt[slot]  <= (fire && ttype == TT_REPEAT) ? '0 : next_cnt;
			filt_prev[slot] <= filtered;
		end
	end

	// ----------------------------------------------------------------
	// execution and write port
	// ----------------------------------------------------------------
	// (R15) (R17) (R18) result computed from the source read
	// (R19) written to the destination in the following cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_en_o   <= 1'b0;
			wr_addr_o <= 16'h0000;
			wr_data_o <= 16'h0000;
		end else if (state == ST_SRC) begin
			wr_en_o   <= 1'b1;
			wr_addr_o <= dst_sel_q[slot];
			wr_data_o <= ree_alu(cur_cfg[EXEC_OP_LSB +: FIELD_W], rd_data_i, src_opd_q[slot]);
		end else begin
			wr_en_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			exec_acc  <= '0;
			exec_mask <= '0;
		end else begin
			if (state == ST_IDLE && tick) begin
				exec_acc <= '0;
			end else if (state == ST_WRITE) begin
				exec_acc[slot] <= 1'b1;
			end
			if (state != ST_IDLE && next_state == ST_IDLE) begin
				exec_mask <= exec_acc | (state == ST_WRITE ? NUM_SLOTS'(1) << slot : '0);
			end
		end
	end

	// a tick during a pass is dropped; set wins over the write-one clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			overrun <= 1'b0;
		end else if (tick && state != ST_IDLE) begin
			overrun <= 1'b1;
		end else if (bus_wr && idx == IDX_STAT && wb_sel_i[0] && wb_dat_i[STAT_OVRUN_BIT]) begin
			overrun <= 1'b0;
		end
	end

endmodule : ree_engine

// *** testbench/ree_engine_asserts.sv ***
// port-level timing checks for the register event engine
module ree_engine_asserts #(
	parameter int TICK_CYCLES = 125000
) (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] rd_addr_o,
	input wire logic [15:0] rd_data_i,
	input wire logic        wr_en_o,
	input wire logic [15:0] wr_addr_o,
	input wire logic [15:0] wr_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	int since_wr;
	// saturates at one period so a quiet engine never reads as a short gap
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			since_wr <= TICK_CYCLES;
		end else if (wr_en_o) begin
			since_wr <= 0;
		end else if (since_wr < TICK_CYCLES) begin
			since_wr <= since_wr + 1;
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_gap;
		!wr_en_o [*2];
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	ack_on_req_a: assert property (s_req |=> s_ans)
		else $error("ack missing or held too long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack after idle bus");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i[11:2]) < 10'h2a8
		|| $past(wb_adr_i[11:2]) > 10'h322) |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	reset_vals_a: assert property ($rose(rst_n_i) |-> !wr_en_o && !wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("outputs not idle after reset");
	wr_gap_a: assert property (wr_en_o |=> s_gap)
		else $error("writes closer than three cycles");
	pass_gap_a: assert property (wr_en_o |-> since_wr <= 64 || since_wr >= TICK_CYCLES - 64)
		else $error("write outside a regulator pass");
endmodule : ree_engine_asserts

// *** testbench/tb_top.sv ***
// self-checking bench for the register event engine
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ree_pkg::*;
	localparam int T = 200;
	localparam logic [15:0] A = 16'h9234;
	localparam logic [15:0] B = 16'h0034;
	logic        clk_i = 0;
	logic        rst_n_i = 0;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        wr_en_o;
	logic [15:0] rd_addr_o;
	logic [15:0] rd_data_i;
	logic [15:0] wr_addr_o;
	logic [15:0] wr_data_o;
	logic [15:0] rq;
	logic [15:0] mem [0:15];
	int          err_total = 0;
	int          check_count = 0;
	int          cyc_n = 0;
	int          wr_n = 0;
	int          trk = 4;
	int          tq[$];

	initial forever #2 clk_i = ~clk_i;
	// bench plays the device register space; numbers above 15 read the complement of the register number
	assign rd_data_i = (rd_addr_o < 16) ? mem[rd_addr_o[3:0]] : ~rd_addr_o;
	always @(posedge clk_i) begin
		cyc_n++;
		if (wr_en_o === 1'b1) begin
			wr_n++;
			mem[wr_addr_o[3:0]] <= wr_data_o;
			if (wr_addr_o == trk) tq.push_back(cyc_n);
		end
	end
	ree_engine #(.TICK_CYCLES(T)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o));
	// ----------------------------------------
	// bus and setup tasks
	// ----------------------------------------
	task automatic wb(input logic w, input logic [9:0] i, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= 4'h3;
		dat <= {16'h0000, d};
		// waits as long as the slave needs; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rq = wb_dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic slot(input logic [9:0] s, input logic [15:0] c, ts, to, ss, so, ds);
		wb(1, IDX_CFG + s, c);
		wb(1, IDX_TRGSEL + s, ts);
		wb(1, IDX_TRGOPD + s, to);
		wb(1, IDX_SRCSEL + s, ss);
		wb(1, IDX_SRCOPD + s, so);
		wb(1, IDX_DSTSEL + s, ds);
	endtask : slot
	// run bit high for exactly p ticks, then let the last pass finish
	task automatic run_for(input int p);
		wb(1, IDX_CTRL, 16'h0001);
		// run is sampled high on exactly p * T edges, so exactly p ticks pass
		repeat (p * T - 3) @(posedge clk_i);
		wb(1, IDX_CTRL, 16'h0000);
		repeat (70) @(posedge clk_i);
	endtask : run_for
	function automatic logic [15:0] f(input logic [3:0] op, input logic [15:0] a, b);
		case (op)
			4'h1: f = 16'(a == b);
			4'h2: f = 16'(a != b);
			4'h3: f = 16'(a < b);
			4'h4: f = 16'(a > b);
			4'h5: f = a | b;
			4'h6: f = ~(a | b);
			4'h7: f = a & b;
			4'h8: f = ~(a & b);
			4'h9: f = a ^ b;
			4'ha: f = ~(a ^ b);
			4'hb: f = a + b;
			4'hc: f = a - b;
			4'hd: f = 16'(a * b);
			4'he: f = (b == 16'h0000) ? 16'h0000 : a / b;
			4'hf: f = b;
			default: f = 16'h0001;
		endcase
	endfunction : f
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		repeat (2 * T) @(posedge clk_i);
		`CHK("idle writes", 0, wr_n)
		wb(0, IDX_CFG, 16'h0000);
		`CHK("cfg reset", 16'h0000, rq)
		wb(0, IDX_CTRL, 16'h0000);
		`CHK("run reset", 16'h0001, rq)
		wb(0, 10'h3ff, 16'h0000);
		`CHK("unmapped", 16'h0000, rq)
		wb(1, IDX_TRGOPD + 10'd19, 16'ha5c3);
		wb(0, IDX_TRGOPD + 10'd19, 16'h0000);
		`CHK("operand rw", 16'ha5c3, rq)
		$display("test reset done");
	endtask : t_reset
	task automatic t_ops;
		for (int op = 0; op < 16; op++) begin
			slot(0, {op[3:0], 12'h000}, 0, 0, 1, B, 2);
			slot(1, {12'hf00, op[3:0]}, 1, B, 0, 16'h5a5a, 3);
			mem[1] <= A;
			mem[2] <= 16'h0000;
			mem[3] <= 16'h0000;
			run_for(2);
			if (op != 0) `CHK("exec op", f(op[3:0], A, B), mem[2])
			`CHK("trig op", (f(op[3:0], A, B) != 0) ? 16'h5a5a : 16'h0000, mem[3])
		end
		slot(0, 16'he000, 0, 0, 1, 16'h0000, 2);
		mem[2] <= 16'hffff;
		run_for(2);
		`CHK("div zero", 16'h0000, mem[2])
		$display("test operators done");
	endtask : t_ops
	task automatic t_repeat;
		for (int n = 0; n < 3; n += 2) begin
			slot(0, {8'hb2, n[3:0], 4'h0}, 0, 0, 4, 16'h0001, 4);
			mem[4] <= 16'h0000;
			tq.delete();
			run_for(9);
			`CHK("reps", 9 >> n, tq.size())
			`CHK("count", 16'(9 >> n), mem[4])
			for (int k = 1; k < tq.size(); k++) `CHK("gap", (1 << n) * T, tq[k] - tq[k - 1])
		end
		$display("test repeat done");
	endtask : t_repeat
	task automatic t_edge;
		trk = 6;
		slot(0, 16'hf111, 5, 16'h0007, 0, 16'h0077, 6);
		tq.delete();
		mem[5] <= 16'h0007;
		run_for(6);
		`CHK("edge once", 1, tq.size())
		`CHK("dest", 16'h0077, mem[6])
		mem[5] <= 16'h0000;
		run_for(2);
		mem[5] <= 16'h0007;
		run_for(6);
		`CHK("rearm", 2, tq.size())
		$display("test edge done");
	endtask : t_edge
	task automatic t_order;
		slot(0, 16'hf000, 0, 0, 0, 16'h0055, 7);
		slot(19, 16'hf001, 7, 16'h0055, 0, 16'h00aa, 8);
		slot(2, 16'hf300, 0, 16'h0000, 0, 16'h0033, 9);
		mem[7] <= 16'h0000;
		mem[8] <= 16'h0000;
		mem[9] <= 16'h0000;
		run_for(1);
		`CHK("same pass", 16'h00aa, mem[8])
		`CHK("bad type", 16'h0000, mem[9])
		$display("test order done");
	endtask : t_order
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_ops();
		t_repeat();
		t_edge();
		t_order();
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end
endmodule : tb_top
bind ree_engine ree_engine_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_addr_o(rd_addr_o),
	.rd_data_i(rd_data_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
